// ==== hw/madc_core.sv ====
// Functional notes
// - two three-channel groups, each picks a generator
// - channel rate is source divided by 1..32
// - each generator divided by fixed 128 first
// - settle done after 20 ms, interrupt capable
// - output clock from external clock or generator 0
// - external clock selectable per channel as source
// - clock forwarded for chains of up to eight
// - group sync by software or sync pin
// - sync output repeats sync for the chain
// - data coded offset binary or two's complement
// - each sample carries 2-bit channel tag
// - buffer holds 64K entries of 18 bits
// - size register reports buffered sample count
// - threshold flag when count at or above threshold
// - threshold 0 sets the flag at any count; maximum 65535 flags one entry below full
// - calibration drives internal reference to all channels
// - calibration at reset and on control bit
// - calibration self-completes, completion interrupt capable
// - all sources merged onto one enabled interrupt
// - 32-bit register reads and writes
// - bus master moves buffer contents to memory
`timescale 1ns/1ps
`default_nettype none
module madc_core
	import madc_pkg::*;
#(
	parameter int SETTLE_CYCLES = SETTLE_CYC,
	parameter int CAL_CYCLES = CAL_CYC
)
(
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RST_IN,
	// apb slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	output logic IRQ_OUT,
	// clock and sync pins
	input wire logic GEN0_CLK_IN,
	input wire logic GEN1_CLK_IN,
	input wire logic EXT_CLK_IN,
	input wire logic SYNC_IN,
	output logic CLK_OUT,
	output logic SYNC_OUT,
	// converters
	output logic [RATE_W-1:0] RATE0_OUT,
	output logic [RATE_W-1:0] RATE1_OUT,
	output logic [NUM_CH-1:0] CONV_OUT,
	input wire logic [NUM_CH*DATA_W-1:0] ADC_DATA_IN,
	output logic CAL_ACTIVE_OUT,
	// dma master
	output logic DMA_VALID_OUT,
	output logic [31:0] DMA_ADDR_OUT,
	output logic [31:0] DMA_DATA_OUT,
	input wire logic DMA_ACK_IN
);
	// pin synchronisers: s1 feeds s2 only, s3 for edges
	logic [3:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
	logic [3:0] pin_rise;
	logic [NSRC-1:0] src_rise;
	logic sync_rise;
	assign pin_rise = pin_s2_reg & ~pin_s3_reg;
	assign src_rise = pin_rise[NSRC-1:0];
	assign sync_rise = pin_rise[3];

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
			pin_s3_reg <= '0;
		end
		else
		begin
			pin_s1_reg <= {SYNC_IN, EXT_CLK_IN, GEN1_CLK_IN, GEN0_CLK_IN};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	// apb decode
	logic acc, wr, rd, ok;
	logic [CTRL_W-1:0] ctrl_reg;
	logic [THR_W-1:0] thr_reg;
	logic [IRQ_W-1:0] irq_en_reg, irq_stat_reg, irq_set;
	logic [31:0] dma_addr_reg;
	logic [DIV_W:0] chan_reg [NUM_CH];
	logic data_wait_reg;
	logic is_data, is_chan;
	logic [7:0] chan_off;
	logic [2:0] chan_idx;
	assign acc = PSEL_IN && PENABLE_IN && PREADY_OUT;
	assign wr = acc && PWRITE_IN;
	assign rd = acc && !PWRITE_IN;
	assign is_data = madc_hit(PADDR_IN, OFF_DATA);
	assign chan_off = PADDR_IN - OFF_CHAN0;
	assign chan_idx = chan_off[4:2];
	assign is_chan = (PADDR_IN >= OFF_CHAN0) && (PADDR_IN < OFF_THRESH);
	assign ok = (PADDR_IN[1:0] == 2'b00) && (PADDR_IN <= OFF_LAST);
	// data reads wait one cycle for the registered ram output
	assign PREADY_OUT = !(is_data && !PWRITE_IN && !data_wait_reg);
	assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !ok;

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			data_wait_reg <= 1'b0;
		end
		else
		begin
			data_wait_reg <= PSEL_IN && PENABLE_IN && is_data && !data_wait_reg;
		end
	end

	// control, rate, channel, threshold, enable and dma address registers
	logic [1:0] rate_wr;
	logic [1:0] swsync;
	logic cal_go;
	assign rate_wr[0] = wr && madc_hit(PADDR_IN, OFF_RATE0);
	assign rate_wr[1] = wr && madc_hit(PADDR_IN, OFF_RATE1);
	assign swsync = (wr && madc_hit(PADDR_IN, OFF_CTRL)) ? PWDATA_IN[CB_SWSYNC0+:2] : 2'b00;
	assign cal_go = wr && madc_hit(PADDR_IN, OFF_CTRL) && PWDATA_IN[CB_CAL];

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			ctrl_reg <= '0;
			RATE0_OUT <= RATE_RST;
			RATE1_OUT <= RATE_RST;
			thr_reg <= THR_RST;
			irq_en_reg <= '0;
			dma_addr_reg <= '0;
			for (int i = 0; i < NUM_CH; i++)
				chan_reg[i] <= '0;
		end
		else
		begin
			if (wr && madc_hit(PADDR_IN, OFF_CTRL))
				ctrl_reg <= PWDATA_IN[CTRL_W-1:0];
			if (rate_wr[0])
				RATE0_OUT <= PWDATA_IN[RATE_W-1:0];
			if (rate_wr[1])
				RATE1_OUT <= PWDATA_IN[RATE_W-1:0];
			if (wr && madc_hit(PADDR_IN, OFF_THRESH))
				thr_reg <= PWDATA_IN[THR_W-1:0];
			if (wr && madc_hit(PADDR_IN, OFF_IRQ_EN))
				irq_en_reg <= PWDATA_IN[IRQ_W-1:0];
			if (wr && is_chan)
				chan_reg[chan_idx] <= PWDATA_IN[DIV_W:0];
			if (wr && madc_hit(PADDR_IN, OFF_DMA_ADDR))
				dma_addr_reg <= PWDATA_IN;
			else if (DMA_VALID_OUT && DMA_ACK_IN)
				dma_addr_reg <= dma_addr_reg + DMA_STEP;
		end
	end

	// generator settle timers, one shared event bit
	logic [31:0] settle_cnt_reg [2];
	logic [1:0] settle_done;
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_settle
			assign settle_done[g] = (settle_cnt_reg[g] == 32'd1);
			always_ff @(posedge CLK_IN or posedge RST_IN)
			begin
				if (RST_IN)
					settle_cnt_reg[g] <= '0;
				else if (rate_wr[g])
					settle_cnt_reg[g] <= SETTLE_CYCLES;
				else if (settle_cnt_reg[g] != '0)
					settle_cnt_reg[g] <= settle_cnt_reg[g] - 32'd1;
			end
		end
	endgenerate

	// fixed divide by 128 on each source edge stream
	logic [PRE_W-1:0] pre_reg [NSRC];
	logic [NSRC-1:0] src_tick;
	generate
		for (g = 0; g < NSRC; g++)
		begin : g_pre
			assign src_tick[g] = src_rise[g] && (pre_reg[g] == '1);
			always_ff @(posedge CLK_IN or posedge RST_IN)
			begin
				if (RST_IN)
					pre_reg[g] <= '0;
				else if (src_rise[g])
					pre_reg[g] <= pre_reg[g] + 1'b1;
			end
		end
	endgenerate

	// calibration sequencer, starts by itself after reset
	madc_cal_e cal_reg, cal_next;
	logic [31:0] cal_cnt_reg;
	logic cal_busy;
	assign cal_busy = (cal_reg == CAL_RUN);
	assign CAL_ACTIVE_OUT = cal_busy;

	always_comb
	begin
		case (cal_reg)
			CAL_IDLE: cal_next = cal_go ? CAL_RUN : CAL_IDLE;
			CAL_RUN: cal_next = (cal_cnt_reg == '0) ? CAL_DONE : CAL_RUN;
			CAL_DONE: cal_next = CAL_IDLE;
			default: cal_next = CAL_IDLE;
		endcase
	end

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			cal_reg <= CAL_RUN;
			cal_cnt_reg <= CAL_CYCLES;
		end
		else
		begin
			cal_reg <= cal_next;
			if (cal_next == CAL_RUN && cal_reg != CAL_RUN)
				cal_cnt_reg <= CAL_CYCLES;
			else if (cal_busy && cal_cnt_reg != '0)
				cal_cnt_reg <= cal_cnt_reg - 32'd1;
		end
	end

	// group sync and per-channel dividers
	logic [1:0] grp_sync;
	logic [NUM_CH-1:0] strobe;
	generate
		for (g = 0; g < 2; g++)
		begin : g_grp
			assign grp_sync[g] = swsync[g] || (ctrl_reg[CB_SYNC_EXT0+g] && sync_rise);
		end
		for (g = 0; g < NUM_CH; g++)
		begin : g_ch
			localparam int GRP = g / GRP_CH;
			logic tick;
			assign tick = chan_reg[g][CH_EXT_BIT] ? src_tick[SRC_EXT] : src_tick[ctrl_reg[CB_GEN_SEL0+GRP]];
			madc_chan_div u_div (
				.clk_in(CLK_IN),
				.rst_in(RST_IN),
				.tick_in(tick && !cal_busy),
				.div_in(chan_reg[g][DIV_W-1:0]),
				.restart_in(grp_sync[GRP]),
				.strobe_out(strobe[g])
			);
		end
	endgenerate

	// clock and sync forwarding for daisy chains
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			CLK_OUT <= 1'b0;
			SYNC_OUT <= 1'b0;
			CONV_OUT <= '0;
		end
		else
		begin
			CLK_OUT <= ctrl_reg[CB_CLKO_GEN] ? pin_s2_reg[0] : pin_s2_reg[SRC_EXT];
			SYNC_OUT <= |grp_sync;
			CONV_OUT <= strobe;
		end
	end

	// capture samples, then write one pending channel per cycle
	madc_sample_s samp_reg [NUM_CH];
	logic [NUM_CH-1:0] pend_reg, pick;
	logic [2:0] pick_idx;
	logic [FIFO_AW-1:0] wr_ptr_reg, rd_ptr_reg;
	logic [CNT_W-1:0] count_reg;
	logic full, empty, push, pop, apb_pop, dma_pop, dma_gap_reg;
	madc_sample_s mem_rd;
	assign pick = pend_reg & (~pend_reg + 1'b1);
	always_comb
	begin
		pick_idx = '0;
		for (int i = 0; i < NUM_CH; i++)
			if (pick[i])
				pick_idx = 3'(i);
	end
	assign full = count_reg[FIFO_AW];
	assign empty = (count_reg == '0);
	assign push = (pend_reg != '0) && !full; // overflow holds samples pending
	assign apb_pop = rd && is_data && !empty;
	assign dma_pop = DMA_VALID_OUT && DMA_ACK_IN;
	assign pop = apb_pop || dma_pop;

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			pend_reg <= '0;
			for (int i = 0; i < NUM_CH; i++)
				samp_reg[i] <= '0;
		end
		else
		begin
			pend_reg <= (pend_reg & ~(push ? pick : '0)) | strobe;
			for (int i = 0; i < NUM_CH; i++)
				if (strobe[i])
				begin
					samp_reg[i].tag <= TAG_W'(i % GRP_CH);
					samp_reg[i].value <= ADC_DATA_IN[i*DATA_W+:DATA_W]
						^ (ctrl_reg[CB_TWOS] ? '0 : SIGN_FLIP);
				end
		end
	end

	madc_fifo_mem u_mem (
		.clk_in(CLK_IN),
		.wr_en_in(push),
		.wr_addr_in(wr_ptr_reg),
		.wr_data_in(samp_reg[pick_idx]),
		.rd_addr_in(rd_ptr_reg),
		.rd_data_out(mem_rd)
	);

	// pointers and count move in the same cycle as the access
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			dma_gap_reg <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			count_reg <= count_reg + CNT_W'(push) - CNT_W'(pop);
			// one-cycle gap after push/pop lets the ram output catch up
			dma_gap_reg <= pop || push;
		end
	end

	// dma presents the head word; apb data reads take priority
	assign DMA_VALID_OUT = ctrl_reg[CB_DMA_EN] && !empty && !dma_gap_reg
		&& !(PSEL_IN && is_data);
	assign DMA_ADDR_OUT = dma_addr_reg;
	assign DMA_DATA_OUT = {{(32-TAG_W-DATA_W){1'b0}}, mem_rd};

	// threshold flag and sticky interrupt status, set wins over clear
	logic thr_flag, thr_prev_reg;
	logic [IRQ_W-1:0] irq_clr;
	assign thr_flag = (count_reg >= CNT_W'(thr_reg));
	assign irq_set[IB_SETTLE] = |settle_done;
	assign irq_set[IB_CAL] = (cal_reg == CAL_DONE);
	assign irq_set[IB_THRESH] = thr_flag && !thr_prev_reg;
	assign irq_clr = (wr && madc_hit(PADDR_IN, OFF_IRQ_STAT)) ? PWDATA_IN[IRQ_W-1:0] : '0;
	assign IRQ_OUT = |(irq_stat_reg & irq_en_reg);

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			irq_stat_reg <= '0;
			thr_prev_reg <= 1'b0;
		end
		else
		begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
			thr_prev_reg <= thr_flag;
		end
	end

	// read data mux
	logic [31:0] status_word;
	assign status_word = {14'h0000, thr_flag, cal_busy, 6'h00, ctrl_reg};
	always_comb
	begin
		PRDATA_OUT = '0;
		if (madc_hit(PADDR_IN, OFF_CTRL))
			PRDATA_OUT = status_word;
		else if (madc_hit(PADDR_IN, OFF_RATE0))
			PRDATA_OUT = 32'(RATE0_OUT);
		else if (madc_hit(PADDR_IN, OFF_RATE1))
			PRDATA_OUT = 32'(RATE1_OUT);
		else if (is_chan)
			PRDATA_OUT = 32'(chan_reg[chan_idx]);
		else if (madc_hit(PADDR_IN, OFF_THRESH))
			PRDATA_OUT = 32'(thr_reg);
		else if (madc_hit(PADDR_IN, OFF_SIZE))
			PRDATA_OUT = 32'(count_reg);
		else if (is_data)
			PRDATA_OUT = empty ? '0 : 32'(mem_rd);
		else if (madc_hit(PADDR_IN, OFF_IRQ_EN))
			PRDATA_OUT = 32'(irq_en_reg);
		else if (madc_hit(PADDR_IN, OFF_IRQ_STAT))
			PRDATA_OUT = 32'(irq_stat_reg);
		else if (madc_hit(PADDR_IN, OFF_DMA_ADDR))
			PRDATA_OUT = dma_addr_reg;
	end
endmodule
`default_nettype wire

// ==== common/madc_pkg.sv ====
`default_nettype none
package madc_pkg;
	// geometry
	localparam int NUM_CH = 6;
	localparam int GRP_CH = 3;
	localparam int DATA_W = 16;
	localparam int TAG_W = 2;
	localparam int DIV_W = 5;
	localparam int PRE_W = 7; // 2**7 = fixed divide by 128
	localparam int FIFO_AW = 16;
	localparam int CNT_W = FIFO_AW + 1;
	localparam int THR_W = 16;
	localparam int RATE_W = 16;
	localparam int NSRC = 3; // gen0, gen1, external
	localparam int SRC_EXT = 2;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_RATE0 = 8'h04;
	localparam logic [7:0] OFF_RATE1 = 8'h08;
	localparam logic [7:0] OFF_CHAN0 = 8'h0c;
	localparam logic [7:0] OFF_THRESH = 8'h24;
	localparam logic [7:0] OFF_SIZE = 8'h28;
	localparam logic [7:0] OFF_DATA = 8'h2c;
	localparam logic [7:0] OFF_IRQ_EN = 8'h30;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h34;
	localparam logic [7:0] OFF_DMA_ADDR = 8'h38;
	localparam logic [7:0] OFF_LAST = 8'h38;
	// control register fields
	localparam int CTRL_W = 10;
	localparam int CB_TWOS = 0;
	localparam int CB_CAL = 1;
	localparam int CB_CLKO_GEN = 2;
	localparam int CB_SYNC_EXT0 = 3;
	localparam int CB_SWSYNC0 = 5;
	localparam int CB_GEN_SEL0 = 7;
	localparam int CB_DMA_EN = 9;
	localparam int SB_CAL_BUSY = 16;
	localparam int SB_THRESH = 17;
	// channel register fields
	localparam int CH_EXT_BIT = 5;
	// interrupt bits
	localparam int IRQ_W = 3;
	localparam int IB_SETTLE = 0;
	localparam int IB_CAL = 1;
	localparam int IB_THRESH = 2;
	// reset values, sign flip mask and dma address step
	localparam logic [RATE_W-1:0] RATE_RST = 16'h0000;
	localparam logic [THR_W-1:0] THR_RST = 16'hfffe;
	localparam logic [15:0] SIGN_FLIP = 16'h8000;
	localparam logic [31:0] DMA_STEP = 32'h0000_0004;
	// timing
	localparam int CLK_KHZ = 100_000;
	localparam int SETTLE_MS = 20;
	localparam int SETTLE_CYC = SETTLE_MS * CLK_KHZ;
	localparam int CAL_S = 2;
	localparam int CAL_CYC = CAL_S * CLK_KHZ * 1000;

	typedef struct packed {
		logic [TAG_W-1:0] tag;
		logic [DATA_W-1:0] value;
	} madc_sample_s;

	typedef enum logic [2:0] {
		CAL_IDLE = 3'b001,
		CAL_RUN = 3'b010,
		CAL_DONE = 3'b100
	} madc_cal_e;

	// register hit decode, shared by writes, reads and strobes
	function automatic logic madc_hit(input logic [7:0] addr, input logic [7:0] off);
		madc_hit = (addr == off);
	endfunction
endpackage
`default_nettype wire

// ==== hw/madc_fifo_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module madc_fifo_mem
	import madc_pkg::*;
(
	// clock
	input wire logic clk_in,
	// write side
	input wire logic wr_en_in,
	input wire logic [FIFO_AW-1:0] wr_addr_in,
	input wire madc_sample_s wr_data_in,
	// read side
	input wire logic [FIFO_AW-1:0] rd_addr_in,
	output madc_sample_s rd_data_out
);
	madc_sample_s mem [0:(1<<FIFO_AW)-1];

	// plain dual port ram, read data from a register
	always_ff @(posedge clk_in)
	begin
		if (wr_en_in)
		begin
			mem[wr_addr_in] <= wr_data_in;
		end
		rd_data_out <= mem[rd_addr_in];
	end
endmodule
`default_nettype wire

// ==== hw/madc_chan_div.sv ====
`timescale 1ns/1ps
`default_nettype none
module madc_chan_div
	import madc_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// rate source
	input wire logic tick_in,
	input wire logic [DIV_W-1:0] div_in,
	input wire logic restart_in,
	// sample strobe
	output logic strobe_out
);
	logic [DIV_W-1:0] cnt_reg;
	logic [DIV_W-1:0] cnt_next;
	logic wrap;

	// divisor is div_in plus one, so 1 through 32
	assign wrap = tick_in && (cnt_reg == div_in);
	assign cnt_next = restart_in ? '0 : wrap ? '0 : tick_in ? cnt_reg + 1'b1 : cnt_reg;

	// counter and strobe register
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cnt_reg <= '0;
			strobe_out <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			strobe_out <= wrap && !restart_in;
		end
	end
endmodule
`default_nettype wire

// ==== verif/madc_dma_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module madc_dma_host
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// dma side
	input wire logic valid_in,
	input wire logic [3:0] lat_in,
	output logic ack_out
);
	logic [3:0] wait_reg;
	// memory takes a word after lat_in idle cycles; ack is a one-cycle pulse
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			wait_reg <= 4'h0;
			ack_out <= 1'b0;
		end
		else
		begin
			ack_out <= valid_in && !ack_out && wait_reg >= lat_in;
			wait_reg <= (valid_in && !ack_out) ? wait_reg + 4'h1 : 4'h0;
		end
	end
endmodule
`default_nettype wire

// ==== verif/madc_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module madc_checker
	import madc_pkg::*;
#(
	parameter int CAL_CYCLES = 100
)
(
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RST_IN,
	// register bus
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	input wire logic IRQ_OUT,
	// sampling and dma
	input wire logic SYNC_OUT,
	input wire logic [NUM_CH-1:0] CONV_OUT,
	input wire logic CAL_ACTIVE_OUT,
	input wire logic DMA_VALID_OUT,
	input wire logic [31:0] DMA_ADDR_OUT,
	input wire logic DMA_ACK_IN
);
	logic wr_w;
	logic ctrl_w;
	logic take_w;
	int cal_cnt_reg;
	// completed writes and dma hand-overs
	assign wr_w = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
	assign ctrl_w = wr_w && PADDR_IN == OFF_CTRL;
	assign take_w = DMA_VALID_OUT && DMA_ACK_IN;
	// cycles spent in the current calibration run
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			cal_cnt_reg <= 0;
		else
			cal_cnt_reg <= CAL_ACTIVE_OUT ? cal_cnt_reg + 1 : 0;
	end
	default clocking @(posedge CLK_IN);
	endclocking
	default disable iff (RST_IN);
	a_bad_addr: assert property (
		PSEL_IN && PENABLE_IN && (PADDR_IN > OFF_LAST || PADDR_IN[1:0] != 2'h0) |-> PSLVERR_OUT)
		else $error("bad address not refused");
	a_data_wait: assert property (
		$rose(PENABLE_IN) && PSEL_IN && !PWRITE_IN && PADDR_IN == OFF_DATA
		|-> !PREADY_OUT ##1 PREADY_OUT) else $error("data read wait state wrong");
	a_irq_hold: assert property (
		IRQ_OUT && !(wr_w && (PADDR_IN == OFF_IRQ_EN || PADDR_IN == OFF_IRQ_STAT)) |=> IRQ_OUT)
		else $error("interrupt dropped without software");
	a_cal_bound: assert property (cal_cnt_reg <= CAL_CYCLES + 2)
		else $error("calibration overran");
	a_cal_full: assert property ($fell(CAL_ACTIVE_OUT) |-> cal_cnt_reg >= CAL_CYCLES)
		else $error("calibration ended early");
	a_cal_restart: assert property (ctrl_w && PWDATA_IN[CB_CAL] |-> ##[1:3] CAL_ACTIVE_OUT)
		else $error("calibration bit did not restart");
	a_cal_quiet: assert property (CAL_ACTIVE_OUT |-> CONV_OUT == '0)
		else $error("conversion during calibration");
	a_sw_sync: assert property (ctrl_w && PWDATA_IN[CB_SWSYNC0] |-> ##[1:3] SYNC_OUT)
		else $error("software sync not forwarded");
	a_dma_gap: assert property (take_w |=> !DMA_VALID_OUT)
		else $error("dma valid held after take");
	a_dma_step: assert property (
		take_w && !(wr_w && PADDR_IN == OFF_DMA_ADDR) |=> DMA_ADDR_OUT == $past(DMA_ADDR_OUT) + DMA_STEP)
		else $error("dma address did not advance");
	a_conv_gap: assert property (CONV_OUT[0] |=> !CONV_OUT[0] [*8])
		else $error("conversion strobes too close");
	// main scenarios reached
	c_cal_end: cover property ($fell(CAL_ACTIVE_OUT));
	c_dma_take: cover property (take_w);
	c_sync: cover property (SYNC_OUT);
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import madc_pkg::*;
;
	localparam int SET_C = 50;
	localparam int CAL_C = 100;
	logic CLK_IN = 0, RST_IN = 1, PSEL_IN = 0, PENABLE_IN = 0, PWRITE_IN = 0, SYNC_IN = 0;
	logic GEN0_CLK_IN = 0, GEN1_CLK_IN = 0, EXT_CLK_IN = 0, DMA_ACK_IN, run = 0, win = 0;
	logic PREADY_OUT, PSLVERR_OUT, IRQ_OUT, CLK_OUT, SYNC_OUT, CAL_ACTIVE_OUT, DMA_VALID_OUT;
	logic [7:0] PADDR_IN = 8'h00;
	logic [31:0] PWDATA_IN = 32'h0, PRDATA_OUT, DMA_ADDR_OUT, DMA_DATA_OUT, rdata, dma_a;
	logic [RATE_W-1:0] RATE0_OUT, RATE1_OUT;
	logic [NUM_CH-1:0] CONV_OUT;
	logic [NUM_CH*DATA_W-1:0] ADC_DATA_IN = '0;
	logic [3:0] lat = 4'h0;
	logic rerr, clko_d, fmt = 1;
	logic [31:0] q[$];
	logic [31:0] slot[6];
	logic [5:0] pend_m = '0;
	int fails = 0, comparisons = 0, cnt[6], clk_n, sync_n;
	int per[6] = '{200, 200, 200, 280, 160, 280};
	logic [5:0] chcfg[6] = '{6'h00, 6'h01, 6'h02, 6'h00, 6'h20, 6'h01};

	madc_core #(.SETTLE_CYCLES(SET_C), .CAL_CYCLES(CAL_C)) u_madc_core (.*);
	madc_dma_host u_madc_dma_host (.clk_in(CLK_IN), .rst_in(RST_IN), .valid_in(DMA_VALID_OUT),
		.lat_in(lat), .ack_out(DMA_ACK_IN));

	// clocks; link clocks stand still between frames, offset from the core clock
	initial
	begin
		forever #5 CLK_IN = ~CLK_IN;
	end
	initial
	begin
		#2.3;
		forever #80 EXT_CLK_IN = run ? ~EXT_CLK_IN : 1'b0;
	end
	initial
	begin
		#3.7;
		forever #100 GEN0_CLK_IN = run ? ~GEN0_CLK_IN : 1'b0;
	end
	initial
	begin
		#1.1;
		forever #140 GEN1_CLK_IN = run ? ~GEN1_CLK_IN : 1'b0;
	end

	task automatic wrap_up;
		if (fails == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one apb transfer; answer taken at the rising edge that sees pready high,
	// only the watchdog ends a wait that never comes
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK_IN);
		PSEL_IN <= 1;
		PWRITE_IN <= w;
		PADDR_IN <= a;
		PWDATA_IN <= d;
		@(posedge CLK_IN);
		PENABLE_IN <= 1;
		@(posedge CLK_IN);
		while (PREADY_OUT !== 1'b1)
		begin
			@(posedge CLK_IN);
		end
		rdata = PRDATA_OUT;
		rerr = PSLVERR_OUT;
		PSEL_IN <= 0;
		PENABLE_IN <= 0;
	endtask

	task automatic cal_wait;
		int n;
		n = 0;
		while (CAL_ACTIVE_OUT !== 1'b0 && n < 500)
		begin
			@(negedge CLK_IN);
			n++;
		end
		chk("cal_done", 1, n < 500);
	endtask

	// reference model: samples in channel order, dma words, clock and sync pulses
	always @(negedge CLK_IN)
	begin
		// one pending sample enters the buffer per cycle, lowest channel first
		for (int i = 0; i < NUM_CH; i++)
			if (pend_m[i])
			begin
				q.push_back(slot[i]);
				pend_m[i] = 1'b0;
				break;
			end
		for (int i = 0; i < NUM_CH; i++)
			if (CONV_OUT[i] === 1'b1)
			begin
				slot[i] = {14'h0, 2'(i % 3), ADC_DATA_IN[16*i+:16] ^ (fmt ? 16'h0 : SIGN_FLIP)};
				pend_m[i] = 1'b1;
				cnt[i] += win;
			end
		clk_n += (win && CLK_OUT === 1'b1 && clko_d === 1'b0);
		clko_d = CLK_OUT;
		sync_n += (win && SYNC_OUT === 1'b1);
		if (DMA_VALID_OUT === 1'b1 && DMA_ACK_IN === 1'b1)
		begin
			chk("dma_data", q.size() ? q.pop_front() : 32'hdead, DMA_DATA_OUT);
			chk("dma_addr", dma_a, DMA_ADDR_OUT);
			dma_a += 4;
			lat <= 4'($urandom_range(3));
		end
	end

	initial
	begin
		logic [31:0] v;
		void'($urandom(32'h518d));
		ADC_DATA_IN <= {$urandom, $urandom, $urandom};
		repeat (4) @(posedge CLK_IN);
		RST_IN <= 0;
		chk("cal_start", 1, CAL_ACTIVE_OUT);
		cal_wait;
		apb(0, OFF_IRQ_STAT, 0);
		chk("cal_irq", 1, rdata[IB_CAL]);
		apb(0, OFF_THRESH, 0);
		chk("thresh_rst", 32'hfffe, rdata);
		apb(0, 8'h3c, 0);
		chk("bad_addr", 1, rerr);
		v = $urandom;
		apb(1, OFF_IRQ_STAT, 32'h7);
		apb(1, OFF_IRQ_EN, 32'h1);
		apb(1, OFF_RATE0, v);
		@(negedge CLK_IN);
		chk("rate0", v[15:0], RATE0_OUT);
		apb(1, OFF_RATE1, ~v);
		@(negedge CLK_IN);
		chk("rate1", {16'h0, ~v[15:0]}, RATE1_OUT);
		apb(0, OFF_IRQ_STAT, 0);
		chk("settle_early", 0, rdata[IB_SETTLE]);
		repeat (SET_C + 4) @(posedge CLK_IN);
		apb(0, OFF_IRQ_STAT, 0);
		chk("settle", 1, rdata[IB_SETTLE]);
		@(negedge CLK_IN);
		chk("irq_on", 1, IRQ_OUT);
		apb(1, OFF_IRQ_STAT, 32'h1);
		@(negedge CLK_IN);
		chk("irq_off", 0, IRQ_OUT);
		for (int i = 0; i < NUM_CH; i++)
			apb(1, OFF_CHAN0 + 8'(4 * i), {26'h0, chcfg[i]});
		// frame one: two's complement, group1 on gen1, software and pin sync
		run <= 1;
		win <= 1;
		apb(1, OFF_CTRL, 32'h129);
		repeat (10000) @(posedge CLK_IN);
		SYNC_IN <= 1;
		repeat (4) @(posedge CLK_IN);
		SYNC_IN <= 0;
		repeat (20000) @(posedge CLK_IN);
		win <= 0;
		run <= 0;
		repeat (20) @(posedge CLK_IN);
		foreach (cnt[i])
		begin
			v = 300000 / (per[i] * 128 * (chcfg[i][4:0] + 1));
			chk("rate", 1, cnt[i] <= v + 2 && cnt[i] + 2 >= v);
		end
		chk("clk_out_ext", 1, clk_n >= 1873 && clk_n <= 1877);
		chk("sync_out", 2, sync_n);
		apb(0, OFF_SIZE, 0);
		chk("size", q.size(), rdata);
		v = q.size();
		apb(1, OFF_THRESH, v);
		apb(0, OFF_CTRL, 0);
		chk("flag_equal", 1, rdata[SB_THRESH]);
		apb(1, OFF_THRESH, v + 1);
		apb(0, OFF_CTRL, 0);
		chk("flag_below", 0, rdata[SB_THRESH]);
		while (q.size() > 0)
		begin
			apb(0, OFF_DATA, 0);
			chk("data", q.pop_front(), rdata);
		end
		apb(0, OFF_DATA, 0);
		chk("empty_read", 0, rdata);
		apb(1, OFF_THRESH, 0);
		apb(0, OFF_CTRL, 0);
		chk("flag_empty", 1, rdata[SB_THRESH]);
		// frame two: offset binary, dma to host memory, clock out from gen0
		dma_a = {22'h0, 8'($urandom), 2'h0};
		apb(1, OFF_DMA_ADDR, dma_a);
		fmt = 0;
		clk_n = 0;
		run <= 1;
		win <= 1;
		apb(1, OFF_CTRL, 32'h304);
		repeat (10000) @(posedge CLK_IN);
		win <= 0;
		run <= 0;
		// samples still in the pin synchronisers land a few cycles later
		repeat (10) @(posedge CLK_IN);
		for (int n = 0; n < 400 && (q.size() > 0 || pend_m != '0); n++)
			@(posedge CLK_IN);
		chk("clk_out_gen", 1, clk_n >= 498 && clk_n <= 502);
		chk("drained", 0, q.size());
		apb(1, OFF_CTRL, 32'h2);
		repeat (3) @(negedge CLK_IN);
		chk("cal_again", 1, CAL_ACTIVE_OUT);
		cal_wait;
		wrap_up;
	end

	// hang guard
	initial
	begin
		#600_000;
		fails++;
		wrap_up;
	end
endmodule
bind madc_core madc_checker #(.CAL_CYCLES(CAL_CYCLES)) u_madc_checker (.*);
`default_nettype wire
